// *** logic/hsr_regs.svh ***
// Purpose: Register offsets, reset values and field codes of the
//          Hall state readout.
// Assumes: Included by bare name from every design file except the package.
// Notes:   Definitions only.
`ifndef HSR_REGS_SVH
`define HSR_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (parameter addresses)
// ----------------------------------------------------------------
`define HSR_OFF_U_LEVEL 12'h3a4
`define HSR_OFF_V_LEVEL 12'h3a6
`define HSR_OFF_W_LEVEL 12'h3a8
`define HSR_OFF_PATTERN 12'h3aa
`define HSR_OFF_DIR 12'h3ac

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSR_RST_LEVEL 8'h01
`define HSR_RST_SYNC 3'h7
`define HSR_RST_PATTERN 3'h0

// ----------------------------------------------------------------
// Field positions within the synchronised Hall vector
// ----------------------------------------------------------------
`define HSR_BIT_U 0
`define HSR_BIT_V 1
`define HSR_BIT_W 2

// ----------------------------------------------------------------
// Feedback type codes that carry Hall switches
// ----------------------------------------------------------------
`define HSR_FB_INC_HALL 8'h0a
`define HSR_FB_SINE_HALL 8'h14

// ----------------------------------------------------------------
// Text digits
// ----------------------------------------------------------------
`define HSR_ASCII_ZERO 8'h30
`define HSR_ASCII_ONE 8'h31

`endif

// *** logic/hsr_pkg.sv ***
// Purpose: Types shared by the Hall state readout modules.
// Assumes: Nothing beyond the language.
// Notes:   Constants live in hsr_regs.svh.
`default_nettype none
package hsr_pkg;
    typedef enum logic [1:0] {
        HSR_DIR_IDLE,
        HSR_DIR_POS,
        HSR_DIR_NEG
    } hsr_dir_t;

    typedef logic [2:0] hsr_pattern_t;
endpackage
`default_nettype wire

// *** logic/hsr_sync.sv ***
// Purpose: Two-stage synchroniser for the three Hall switch inputs.
// Assumes: Inputs may change at any time relative to clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
`include "hsr_regs.svh"
module hsr_sync (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [2:0] hall_in, // Raw switches, W V U
    output hsr_pkg::hsr_pattern_t sync_out // Synchronised switches
);
    import hsr_pkg::*;

    logic [2:0] meta;

    // ------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta[i] <= 1'(`HSR_RST_SYNC >> i);
                sync_out[i] <= 1'(`HSR_RST_SYNC >> i);
            end else begin
                meta[i] <= hall_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end

    a_sync_two_stage: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> sync_out == $past(hall_in, 2))
        else $error("Hall synchroniser latency is not two cycles");
endmodule
`default_nettype wire

// *** logic/hsr_dir_track.sv ***
// Purpose: Tells rotation direction from successive Hall patterns.
// Assumes: Pattern is already synchronised and gated.
// Notes:   Codes 0 and 7 and skipped steps count as bad steps.
`timescale 1ns/100ps
`default_nettype none
`include "hsr_regs.svh"
module hsr_dir_track (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [2:0] pattern, // Current weighted pattern
    input wire logic pattern_ok, // Pattern is meaningful
    output hsr_pkg::hsr_dir_t dir, // Last seen direction
    output logic step_pos, // Pulse on positive step
    output logic step_neg, // Pulse on negative step
    output logic step_bad // Pulse on illegal step
);
    import hsr_pkg::*;

    logic [2:0] prev_pattern;
    logic prev_ok;
    logic [2:0] next_prev_pattern;
    logic next_prev_ok;
    hsr_dir_t next_dir;
    logic next_step_pos;
    logic next_step_neg;
    logic next_step_bad;

    // Positive order 1,5,4,6,2,3,1
    function automatic logic [2:0] pos_succ(input logic [2:0] p);
        case (p)
            3'h1: pos_succ = 3'h5;
            3'h5: pos_succ = 3'h4;
            3'h4: pos_succ = 3'h6;
            3'h6: pos_succ = 3'h2;
            3'h2: pos_succ = 3'h3;
            3'h3: pos_succ = 3'h1;
            default: pos_succ = 3'h0;
        endcase
    endfunction

    always_comb begin
        next_prev_pattern = pattern;
        next_prev_ok = pattern_ok;
        next_dir = dir;
        next_step_pos = 1'b0;
        next_step_neg = 1'b0;
        next_step_bad = 1'b0;
        if (pattern_ok && prev_ok && pattern != prev_pattern) begin
            if (pattern == 3'h0 || pattern == 3'h7 ||
                prev_pattern == 3'h0 || prev_pattern == 3'h7) begin
                next_step_bad = 1'b1;
            end else if (pattern == pos_succ(prev_pattern)) begin
                next_step_pos = 1'b1;
                next_dir = HSR_DIR_POS;
            end else if (prev_pattern == pos_succ(pattern)) begin
                next_step_neg = 1'b1;
                next_dir = HSR_DIR_NEG;
            end else begin
                next_step_bad = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_pattern <= `HSR_RST_PATTERN;
            prev_ok <= 1'b0;
            dir <= HSR_DIR_IDLE;
            step_pos <= 1'b0;
            step_neg <= 1'b0;
            step_bad <= 1'b0;
        end else begin
            prev_pattern <= next_prev_pattern;
            prev_ok <= next_prev_ok;
            dir <= next_dir;
            step_pos <= next_step_pos;
            step_neg <= next_step_neg;
            step_bad <= next_step_bad;
        end
    end

    sequence s_pair_ok;
        $past(rst_n) && pattern_ok && $past(pattern_ok);
    endsequence
    sequence s_pos_pair;
        s_pair_ok and ($past(pattern) == 3'h1 && pattern == 3'h5);
    endsequence
    sequence s_neg_pair;
        s_pair_ok and ($past(pattern) == 3'h1 && pattern == 3'h3);
    endsequence

    a_pos_order_step: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pos_pair |=> step_pos && !step_neg && dir == HSR_DIR_POS)
        else $error("Step 1 to 5 not taken as positive");
    a_neg_order_step: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_neg_pair |=> step_neg && !step_pos && dir == HSR_DIR_NEG)
        else $error("Step 1 to 3 not taken as negative");
endmodule
`default_nettype wire

// *** logic/hsr_readout.sv ***
// Purpose: Hall switch readout: levels, weighted pattern, text form,
//          direction, and a read-only parameter port.
// Assumes: One clock; parameter port requests are synchronous.
//          Hall pins may move at any time.
// Notes:   Every register here is read-only to the port.
//          Levels, text and pattern trail the pins by three
//          clocks and direction by four.
//
// Operation
// - U weighs 1, V 2, W 4
// - Pattern is one integer, 0 to 7
// - No switch active reads zero
// - Text is three digits, U V W
// - Low level reads 0, high reads 1
// - Orders 1,5,4,6,2,3 and 1,3,2,6,4,5
// - U level read-only, 0/1, default 1
// - V level read-only, 0/1, default 1
// - W level read-only, 0/1, default 1
// - Pattern valid only for Hall encoders
`timescale 1ns/100ps
`default_nettype none
`include "hsr_regs.svh"
module hsr_readout (
    input wire logic clk, // System clock, 10 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic hall_u_in, // Hall switch U
    input wire logic hall_v_in, // Hall switch V
    input wire logic hall_w_in, // Hall switch W
    input wire logic [7:0] fb_identified, // Feedback type code
    input wire logic [11:0] reg_addr, // Parameter address
    input wire logic reg_rd, // Read request
    input wire logic reg_wr, // Write request
    input wire logic [7:0] reg_wdata, // Write data, discarded
    output logic [7:0] reg_rdata, // Read data
    output logic reg_ack, // Request answered
    output logic reg_err, // Request refused
    output logic [7:0] hall_u_level, // U level
    output logic [7:0] hall_v_level, // V level
    output logic [7:0] hall_w_level, // W level
    output hsr_pkg::hsr_pattern_t hall_pattern_value, // Weighted sum
    output logic hall_pattern_valid, // Pattern meaningful
    output logic [23:0] hall_text, // ASCII digits U V W
    output hsr_pkg::hsr_dir_t hall_dir, // Rotation direction
    output logic step_pos, // Pulse, positive step
    output logic step_neg, // Pulse, negative step
    output logic step_bad // Pulse, illegal step
);
    import hsr_pkg::*;

    hsr_pattern_t hall_sync;
    logic hall_type;
    logic [7:0] next_u_level;
    logic [7:0] next_v_level;
    logic [7:0] next_w_level;
    hsr_pattern_t next_pattern;
    logic next_pattern_valid;
    logic [23:0] next_text;
    logic [7:0] next_rdata;
    logic next_ack;
    logic next_err;
    logic [7:0] dir_code;
    logic wr_unused;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    // Pins are asynchronous to clk; two flops keep a
    // metastable sample away from the pattern logic
    hsr_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .hall_in({hall_w_in, hall_v_in, hall_u_in}),
        .sync_out(hall_sync)
    );

    // ------------------------------------------------------------
    // Levels, pattern and text
    // ------------------------------------------------------------
    // Feedback type change reaches the pattern one clock later
    // Only encoder types that carry Hall switches give a meaning
    assign hall_type = fb_identified == `HSR_FB_INC_HALL ||
                       fb_identified == `HSR_FB_SINE_HALL;

    function automatic logic [7:0] digit(input logic b);
        digit = b ? `HSR_ASCII_ONE : `HSR_ASCII_ZERO;
    endfunction

    always_comb begin
        // High voltage reads 1, low reads 0
        next_u_level = {7'h00, hall_sync[`HSR_BIT_U]};
        next_v_level = {7'h00, hall_sync[`HSR_BIT_V]};
        next_w_level = {7'h00, hall_sync[`HSR_BIT_W]};
        next_pattern_valid = hall_type;
        next_pattern = `HSR_RST_PATTERN;
        if (hall_type) begin
            next_pattern = {2'b00, hall_sync[`HSR_BIT_U]} +
                           {1'b0, hall_sync[`HSR_BIT_V], 1'b0} +
                           {hall_sync[`HSR_BIT_W], 2'b00};
        end
        // Text is not gated; only the pattern is
        next_text = {digit(hall_sync[`HSR_BIT_U]),
                     digit(hall_sync[`HSR_BIT_V]),
                     digit(hall_sync[`HSR_BIT_W])};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hall_u_level <= `HSR_RST_LEVEL;
            hall_v_level <= `HSR_RST_LEVEL;
            hall_w_level <= `HSR_RST_LEVEL;
            hall_pattern_value <= `HSR_RST_PATTERN;
            hall_pattern_valid <= 1'b0;
            hall_text <= {`HSR_ASCII_ONE, `HSR_ASCII_ONE, `HSR_ASCII_ONE};
        end else begin
            hall_u_level <= next_u_level;
            hall_v_level <= next_v_level;
            hall_w_level <= next_w_level;
            hall_pattern_value <= next_pattern;
            hall_pattern_valid <= next_pattern_valid;
            hall_text <= next_text;
        end
    end

    // ------------------------------------------------------------
    // Direction tracker
    // ------------------------------------------------------------
    // Direction is judged on the registered pattern, so a step
    // pulse trails the pattern by one clock
    hsr_dir_track u_dir (
        .clk(clk),
        .rst_n(rst_n),
        .pattern(hall_pattern_value),
        .pattern_ok(hall_pattern_valid),
        .dir(hall_dir),
        .step_pos(step_pos),
        .step_neg(step_neg),
        .step_bad(step_bad)
    );

    // ------------------------------------------------------------
    // Parameter port
    // ------------------------------------------------------------
    always_comb begin
        // Codes software sees: 0 idle, 1 positive, 2 negative
        unique case (hall_dir)
            HSR_DIR_IDLE: dir_code = 8'h00;
            HSR_DIR_POS: dir_code = 8'h01;
            HSR_DIR_NEG: dir_code = 8'h02;
            default: dir_code = 8'h00;
        endcase
    end

    // Write data is dropped on purpose; nothing here is writable
    assign wr_unused = ^reg_wdata;

    // Answer one clock after the strobe, one cycle wide, so
    // requests may follow each other every cycle; read wins
    // over write when both strobes are high
    always_comb begin
        next_rdata = 8'h00;
        next_ack = reg_rd || reg_wr;
        next_err = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                `HSR_OFF_U_LEVEL: next_rdata = hall_u_level;
                `HSR_OFF_V_LEVEL: next_rdata = hall_v_level;
                `HSR_OFF_W_LEVEL: next_rdata = hall_w_level;
                `HSR_OFF_PATTERN: next_rdata = {5'h00, hall_pattern_value};
                `HSR_OFF_DIR: next_rdata = dir_code;
                default: next_err = 1'b1;
            endcase
        end else if (reg_wr) begin
            // Refused without touching any stored value
            next_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_ack <= next_ack;
            reg_err <= next_err;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Levels follow the pins three clocks late, counted from release
    sequence s_settled;
        $past(rst_n, 3);
    endsequence
    sequence s_write_only;
        reg_wr && !reg_rd;
    endsequence

    a_pattern_weights: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_pattern_valid |-> hall_pattern_value ==
            {hall_w_level[0], hall_v_level[0], hall_u_level[0]})
        else $error("Pattern is not the weighted sum of levels");

    a_pattern_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `HSR_OFF_PATTERN
        |=> reg_ack && reg_rdata == {5'h00, $past(hall_pattern_value)})
        else $error("Pattern read does not return the pattern");

    a_pattern_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_u_level[0] == 1'b0 && hall_v_level[0] == 1'b0 &&
        hall_w_level[0] == 1'b0 |-> hall_pattern_value == 3'h0)
        else $error("No switch active but pattern not zero");

    a_text_order: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_text == {digit(hall_u_level[0]), digit(hall_v_level[0]),
                      digit(hall_w_level[0])})
        else $error("Text digits not in U V W order");

    a_level_tracks_pin: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_settled |-> hall_u_level[0] == $past(hall_u_in, 3) &&
            hall_v_level[0] == $past(hall_v_in, 3) &&
            hall_w_level[0] == $past(hall_w_in, 3))
        else $error("Level does not follow its pin in three cycles");

    a_u_level_binary: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_u_level[7:1] == 7'h00 and
        (!$past(rst_n) |-> hall_u_level == `HSR_RST_LEVEL))
        else $error("U level outside 0 and 1 or bad default");

    a_v_level_binary: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_v_level[7:1] == 7'h00 and
        (!$past(rst_n) |-> hall_v_level == `HSR_RST_LEVEL))
        else $error("V level outside 0 and 1 or bad default");

    a_w_level_binary: assert property (
        @(posedge clk) disable iff (!rst_n)
        hall_w_level[7:1] == 7'h00 and
        (!$past(rst_n) |-> hall_w_level == `HSR_RST_LEVEL))
        else $error("W level outside 0 and 1 or bad default");

    a_pattern_gated: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> hall_pattern_valid == $past(hall_type) &&
            (hall_pattern_valid || hall_pattern_value == 3'h0))
        else $error("Pattern shown for a non-Hall feedback type");

    a_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_write_only |=> reg_ack && reg_err && reg_rdata == 8'h00)
        else $error("Write was not refused");

    a_u_level_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `HSR_OFF_U_LEVEL
        |=> reg_ack && !reg_err && reg_rdata == $past(hall_u_level))
        else $error("U level read does not return the level");

    a_v_level_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `HSR_OFF_V_LEVEL
        |=> reg_ack && !reg_err && reg_rdata == $past(hall_v_level))
        else $error("V level read does not return the level");

    a_w_level_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `HSR_OFF_W_LEVEL
        |=> reg_ack && !reg_err && reg_rdata == $past(hall_w_level))
        else $error("W level read does not return the level");

    a_dir_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `HSR_OFF_DIR |=> reg_ack && !reg_err &&
            reg_rdata == ($past(hall_dir) == HSR_DIR_POS ? 8'h01 :
                          $past(hall_dir) == HSR_DIR_NEG ? 8'h02 : 8'h00))
        else $error("Direction read returns a wrong code");

    a_write_keeps_levels: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_write_only |=>
            hall_u_level == {7'h00, $past(hall_sync[`HSR_BIT_U])} &&
            hall_v_level == {7'h00, $past(hall_sync[`HSR_BIT_V])} &&
            hall_w_level == {7'h00, $past(hall_sync[`HSR_BIT_W])})
        else $error("Write disturbed a level");

    a_text_default: assert property (
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |->
            hall_text == {`HSR_ASCII_ONE, `HSR_ASCII_ONE, `HSR_ASCII_ONE})
        else $error("Text default is not one one one");

    a_step_exclusive: assert property (
        @(posedge clk) disable iff (!rst_n)
        $onehot0({step_pos, step_neg, step_bad}))
        else $error("More than one step pulse at once");
endmodule
`default_nettype wire

// *** sim/hsr_hall_model.sv ***
// Purpose: Three Hall switch sensors facing the readout.
// Assumes: The bench names the wanted pattern, bit0 U, bit1 V, bit2 W.
// Notes:   Push-pull outputs, so no released or floating state exists.
`timescale 1ns/100ps
`default_nettype none
module hsr_hall_model (
    input wire logic clk, // System clock
    input wire logic [2:0] want, // Wanted switch pattern
    output logic hall_u, // Switch U level
    output logic hall_v, // Switch V level
    output logic hall_w // Switch W level
);
    // ------------------------------------------------------------
    // Sensor levels
    // ------------------------------------------------------------
    // Late edge so pins move unrelated to the sampling instant
    always @(posedge clk) begin
        #37;
        {hall_w, hall_v, hall_u} = want;
    end
    initial begin
        {hall_w, hall_v, hall_u} = 3'h7;
    end
endmodule
`default_nettype wire

// *** sim/hall_state_readout_tb_top.sv ***
// Purpose: Self-checking bench for the Hall state readout.
// Assumes: Sensor model in hsr_hall_model; seed fixed at 44.
// Notes:   Expected values come from the bench's own functions.
`timescale 1ns/100ps
`default_nettype none
`include "hsr_regs.svh"
module hall_state_readout_tb_top;
    import hsr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] want = 3'h7;
    logic hall_u, hall_v, hall_w;
    logic [7:0] fb_identified = `HSR_FB_INC_HALL;
    logic [11:0] reg_addr = 12'h000;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, hall_u_level, hall_v_level, hall_w_level;
    logic reg_ack, reg_err, hall_pattern_valid;
    logic step_pos, step_neg, step_bad;
    hsr_pattern_t hall_pattern_value;
    hsr_dir_t hall_dir;
    logic [23:0] hall_text;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 44;
    int np, nn, nb;
    logic [2:0] pv;

    always #50 clk = ~clk;

    hsr_hall_model sensors (.clk(clk), .want(want), .hall_u(hall_u),
        .hall_v(hall_v), .hall_w(hall_w));

    hsr_readout uut (.clk(clk), .rst_n(rst_n), .hall_u_in(hall_u),
        .hall_v_in(hall_v), .hall_w_in(hall_w),
        .fb_identified(fb_identified), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .hall_u_level(hall_u_level), .hall_v_level(hall_v_level),
        .hall_w_level(hall_w_level),
        .hall_pattern_value(hall_pattern_value),
        .hall_pattern_valid(hall_pattern_valid), .hall_text(hall_text),
        .hall_dir(hall_dir), .step_pos(step_pos), .step_neg(step_neg),
        .step_bad(step_bad));

    // ------------------------------------------------------------
    // Expectations and checking
    // ------------------------------------------------------------
    function automatic logic [7:0] digit(input logic b);
        return b ? `HSR_ASCII_ONE : `HSR_ASCII_ZERO;
    endfunction

    function automatic logic [23:0] exp_text(input logic [2:0] p);
        return {digit(p[0]), digit(p[1]), digit(p[2])};
    endfunction

    // Weighted sum, written out rather than as a bit concatenation
    function automatic logic [2:0] exp_pat(input logic [2:0] p);
        return 3'(p[0] * 1 + p[1] * 2 + p[2] * 4);
    endfunction

    task automatic check(input string name, input logic [23:0] seen,
        input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Port tasks
    // ------------------------------------------------------------
    // One request, answer checked in the cycle it stands
    task automatic acc(input logic wr, input logic [11:0] a,
        input logic [7:0] exp_d, input logic exp_e);
        @(posedge clk);
        reg_rd <= ~wr;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= 8'($random(seed));
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        check("reg_ack", reg_ack, 1'b1);
        check("reg_err", reg_err, exp_e);
        check("reg_rdata", reg_rdata, exp_d);
    endtask

    // Move the switches and count the step pulses that follow
    task automatic apply(input logic [2:0] p, input logic ok);
        @(posedge clk);
        want <= p;
        np = 0;
        nn = 0;
        nb = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            np += int'(step_pos);
            nn += int'(step_neg);
            nb += int'(step_bad);
        end
        check("u_level", hall_u_level, {7'h00, p[0]});
        check("v_level", hall_v_level, {7'h00, p[1]});
        check("w_level", hall_w_level, {7'h00, p[2]});
        check("text", hall_text, exp_text(p));
        check("pattern", hall_pattern_value,
            ok ? exp_pat(p) : 3'h0);
        check("valid", hall_pattern_valid, ok);
    endtask

    task automatic steps(input logic [2:0] p, input int ep, input int en,
        input int eb, input hsr_dir_t ed);
        apply(p, 1'b1);
        check("n_pos", np, ep);
        check("n_neg", nn, en);
        check("n_bad", nb, eb);
        check("dir", hall_dir, ed);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1;
        check("rst_u", hall_u_level, `HSR_RST_LEVEL);
        check("rst_v", hall_v_level, `HSR_RST_LEVEL);
        check("rst_w", hall_w_level, `HSR_RST_LEVEL);
        check("rst_pat", hall_pattern_value, `HSR_RST_PATTERN);
        check("rst_dir", hall_dir, HSR_DIR_IDLE);
        @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, `HSR_OFF_U_LEVEL, `HSR_RST_LEVEL, 1'b0);
        // Every code, both Hall feedback types
        for (int i = 0; i < 8; i++) begin
            fb_identified <= i[0] ? `HSR_FB_SINE_HALL : `HSR_FB_INC_HALL;
            apply(3'(i), 1'b1);
            acc(1'b0, `HSR_OFF_PATTERN, {5'h00, 3'(i)}, 1'b0);
        end
        // 7 to 1 is illegal; the last legal step, 4 to 5, was negative
        steps(3'h1, 0, 0, 1, HSR_DIR_NEG);
        // Positive walk 5,4,6,2,3,1 starting from 1
        for (int k = 0; k < 6; k++) begin
            pv = 3'(18'o546231 >> (15 - 3 * k));
            steps(pv, 1, 0, 0, HSR_DIR_POS);
        end
        acc(1'b0, `HSR_OFF_DIR, 8'h01, 1'b0);
        // Negative walk 3,2,6,4,5, then 5 to 1 closes the loop
        for (int k = 0; k < 5; k++) begin
            pv = 3'(15'o32645 >> (12 - 3 * k));
            steps(pv, 0, 1, 0, HSR_DIR_NEG);
        end
        steps(3'h1, 0, 1, 0, HSR_DIR_NEG);
        acc(1'b0, `HSR_OFF_DIR, 8'h02, 1'b0);
        steps(3'h6, 0, 0, 1, HSR_DIR_NEG);
        steps(3'h7, 0, 0, 1, HSR_DIR_NEG);
        // Writes refused at the three level offsets and the pattern offset, values left alone
        apply(3'h5, 1'b1);
        acc(1'b1, `HSR_OFF_U_LEVEL, 8'h00, 1'b1);
        acc(1'b1, `HSR_OFF_V_LEVEL, 8'h00, 1'b1);
        acc(1'b1, `HSR_OFF_W_LEVEL, 8'h00, 1'b1);
        acc(1'b1, `HSR_OFF_PATTERN, 8'h00, 1'b1);
        acc(1'b0, `HSR_OFF_U_LEVEL, 8'h01, 1'b0);
        acc(1'b0, `HSR_OFF_V_LEVEL, 8'h00, 1'b0);
        acc(1'b0, `HSR_OFF_W_LEVEL, 8'h01, 1'b0);
        acc(1'b0, `HSR_OFF_PATTERN, 8'h05, 1'b0);
        acc(1'b0, 12'h3a5, 8'h00, 1'b1);
        acc(1'b0, 12'h000, 8'h00, 1'b1);
        // Random codes and feedback types, some without Halls
        repeat (24) begin
            pv = 3'($random(seed));
            case (2'($random(seed)))
                2'h0: fb_identified <= `HSR_FB_INC_HALL;
                2'h1: fb_identified <= `HSR_FB_SINE_HALL;
                2'h2: fb_identified <= 8'h0b;
                default: fb_identified <= 8'h28;
            endcase
            #1;
            apply(pv, fb_identified == `HSR_FB_INC_HALL ||
                fb_identified == `HSR_FB_SINE_HALL);
        end
        fb_identified <= 8'h15;
        apply(3'h6, 1'b0);
        acc(1'b0, `HSR_OFF_PATTERN, 8'h00, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
